// file: uff_triple.sv
`timescale 1ns/1ns
`include "uff_regs.svh"

// Function
// - Three independent stages, sharing only the common clear line.
// - Each stage has two sets, two clears, steering, clock, both outputs.
// - A direct input low 80 ns forces set or clear, clock ignored.
// - Common clear low 80 ns clears all three stages together.
// - Steering inputs are enabled when high, disabled when low.
// - Steered changes happen only on a falling edge of its clock.
// - Complementary direct set and clear load a stage in one step.

module uff_triple #(
  parameter int STAGES = `UFF_STAGES
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  // Direct inputs, active low, two of each per stage, plus the shared common clear
  input wire logic [STAGES-1:0] DC_SET_A_N_IN,
  input wire logic [STAGES-1:0] DC_SET_B_N_IN,
  input wire logic [STAGES-1:0] DC_CLR_A_N_IN,
  input wire logic [STAGES-1:0] DC_CLR_B_N_IN,
  input wire logic COMMON_CLR_N_IN,
  // Steering and clock per stage
  input wire logic [STAGES-1:0] STEER_SET_IN,
  input wire logic [STAGES-1:0] STEER_CLR_IN,
  input wire logic [STAGES-1:0] STAGE_CLK_IN,
  // Stage outputs
  output logic [STAGES-1:0] Q_OUT,
  output logic [STAGES-1:0] Q_N_OUT
);

  // ==========================================================
  // Pin synchronisers, three flops per pin
  localparam int PINS = 7 * STAGES + 1;
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] sync3;
  logic [PINS-1:0] pin_val;

  assign pin_raw = {COMMON_CLR_N_IN, STAGE_CLK_IN, STEER_CLR_IN,
    STEER_SET_IN, DC_CLR_B_N_IN, DC_CLR_A_N_IN, DC_SET_B_N_IN,
    DC_SET_A_N_IN};

  always_ff @(posedge REF_CLK_IN) begin
    sync1 <= pin_raw;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // A change counts once second and third flops agree
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      pin_val <= {PINS{1'b1}}
        & ~(PINS'({STAGES{1'b1}}) << (4 * STAGES))
        & ~(PINS'({STAGES{1'b1}}) << (5 * STAGES))
        & ~(PINS'({STAGES{1'b1}}) << (6 * STAGES));
    end else begin
      pin_val <= (sync2 & sync3) | (pin_val & (sync2 ^ sync3));
    end
  end

  // ==========================================================
  // Clock falling edge detection per stage
  logic [STAGES-1:0] clk_prev;
  logic [STAGES-1:0] clk_fall;

  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN) begin
      clk_prev <= '0;
    end else begin
      clk_prev <= pin_val[6*STAGES +: STAGES];
    end
  end

  assign clk_fall = clk_prev & ~pin_val[6*STAGES +: STAGES];

  // ==========================================================
  // Stages
  genvar i;
  generate
    for (i = 0; i < STAGES; i = i + 1) begin : g_stage
      logic set_n;
      logic clr_n;
      // Either direct input of a pair acts; common clear reaches all
      assign set_n = pin_val[i] & pin_val[STAGES + i];
      assign clr_n = pin_val[2*STAGES + i] & pin_val[3*STAGES + i]
        & pin_val[PINS-1];
      uff_stage u_stage (
        .clk(REF_CLK_IN),
        .rst(RST_IN),
        .dc_set_n(set_n),
        .dc_clr_n(clr_n),
        .steer_set(pin_val[4*STAGES + i]),
        .steer_clr(pin_val[5*STAGES + i]),
        .clk_fall(clk_fall[i]),
        .q(Q_OUT[i]),
        .q_n(Q_N_OUT[i])
      );
    end
  endgenerate

  // ==========================================================
  // Checks
  logic [3:0] cclr_low;
  always_ff @(posedge REF_CLK_IN) begin
    if (RST_IN || pin_val[PINS-1]) begin
      cclr_low <= '0;
    end else if (cclr_low != 4'hF) begin
      cclr_low <= cclr_low + 4'h1;
    end
  end

  a_common_clear: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    cclr_low == 4'hB |-> Q_OUT == '0)
    else $error("common clear did not clear all stages");

  sequence s_quiet;
    pin_val[PINS-1] && (&pin_val[4*STAGES-1:0]);
  endsequence

  a_rise_holds: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    (s_quiet and (clk_fall == '0)) |=> $stable(Q_OUT))
    else $error("stage changed without falling clock");

  a_toggle_step: assert property (@(posedge REF_CLK_IN) disable iff (RST_IN)
    s_quiet ##1 (s_quiet and (clk_fall[0] && pin_val[4*STAGES]
    && pin_val[5*STAGES])) |=> Q_OUT[0] != $past(Q_OUT[0]))
    else $error("stage 0 did not toggle");

endmodule

// file: uff_regs.svh
`ifndef UFF_REGS_SVH
`define UFF_REGS_SVH

// ==========================================================
// Timing
`define UFF_CLK_PERIOD_NS 8
`define UFF_DC_MIN_NS 80
// Least time rounds up to whole cycles
`define UFF_DC_MIN_CYC ((`UFF_DC_MIN_NS + `UFF_CLK_PERIOD_NS - 1) / `UFF_CLK_PERIOD_NS)
`define UFF_DC_CNT_W 4

// ==========================================================
// Stage count
`define UFF_STAGES 3

`endif

// file: uff_pkg.sv
package uff_pkg;
  typedef enum logic [1:0] {
    ACT_HOLD = 2'h0,
    ACT_SET = 2'h1,
    ACT_TOGGLE = 2'h3,
    ACT_CLEAR = 2'h2
  } action_type;
endpackage

// file: uff_stage.sv
`timescale 1ns/1ns
`include "uff_regs.svh"

module uff_stage (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Synchronised stage inputs
  input wire logic dc_set_n,
  input wire logic dc_clr_n,
  input wire logic steer_set,
  input wire logic steer_clr,
  input wire logic clk_fall,
  // Outputs
  output logic q,
  output logic q_n
);

  // ==========================================================
  // Low-time qualifiers for direct inputs
  logic [`UFF_DC_CNT_W-1:0] set_cnt;
  logic [`UFF_DC_CNT_W-1:0] clr_cnt;
  logic set_hit;
  logic clr_hit;
  uff_pkg::action_type act;

  assign set_hit = !dc_set_n &&
    (set_cnt >= `UFF_DC_CNT_W'(`UFF_DC_MIN_CYC - 1));
  assign clr_hit = !dc_clr_n &&
    (clr_cnt >= `UFF_DC_CNT_W'(`UFF_DC_MIN_CYC - 1));

  always_ff @(posedge clk) begin
    if (rst || dc_set_n) begin
      set_cnt <= '0;
    end else if (!set_hit) begin
      set_cnt <= set_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || dc_clr_n) begin
      clr_cnt <= '0;
    end else if (!clr_hit) begin
      clr_cnt <= clr_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Steering decode
  assign act = uff_pkg::action_type'({steer_clr, steer_set});

  // ==========================================================
  // Stored state
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set_hit || clr_hit) begin
      q <= set_hit && !clr_hit;
    end else if (clk_fall) begin
      unique case (act)
        uff_pkg::ACT_HOLD: q <= q;
        uff_pkg::ACT_SET: q <= 1'b1;
        uff_pkg::ACT_TOGGLE: q <= !q;
        uff_pkg::ACT_CLEAR: q <= 1'b0;
      endcase
    end
  end

  // Both direct inputs forced: q_n held high and q cleared, so clear wins
  assign q_n = (set_hit && clr_hit) ? 1'b1 : !q;

  // ==========================================================
  // Checks
  a_dc_set_forces: assert property (@(posedge clk) disable iff (rst)
    set_hit && !clr_hit |=> q)
    else $error("direct set did not set stage");

  a_comp_inverse: assert property (@(posedge clk) disable iff (rst)
    !(set_hit && clr_hit) |-> (q_n == !q))
    else $error("complement output not inverse");

  a_short_pulse: assert property (@(posedge clk) disable iff (rst)
    dc_set_n ##1 (!dc_set_n)[*8] |-> !set_hit)
    else $error("short direct pulse accepted");

endmodule

// file: pin_driver.sv
`timescale 1ns/1ns
// ========================================
// Outside logic on the card pins
module pin_driver (
  // Clock
  input wire logic clk_in,
  // Direct, steering and stage clock pins
  output logic [2:0] sa_n_out,
  output logic [2:0] sb_n_out,
  output logic [2:0] ca_n_out,
  output logic [2:0] cb_n_out,
  output logic cc_n_out,
  output logic [2:0] ss_out,
  output logic [2:0] sc_out,
  output logic [2:0] ck_out
);
  // Idle: pulled-up directs high, steering and clocks low
  initial put(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, 3'h0, 3'h0, 3'h0, 0);

  // Set all pins, then hold them for n cycles
  task automatic put(input logic [2:0] sa, sb, ca, cb, input logic cc,
    input logic [2:0] ss, sc, ck, input int n);
    sa_n_out = sa;
    sb_n_out = sb;
    ca_n_out = ca;
    cb_n_out = cb;
    cc_n_out = cc;
    ss_out = ss;
    sc_out = sc;
    ck_out = ck;
    repeat (n) @(negedge clk_in);
  endtask
endmodule

// file: tb_triple_universal_flip_flop.sv
`timescale 1ns/1ns
module tb_triple_universal_flip_flop;
  // ========================================
  // Signals
  logic ref_clk;
  logic rst = 1'b1;
  wire logic [2:0] sa, sb, ca, cb, ss, sc, ck, q, qn;
  wire logic cc;
  logic [5:0] notes[$];
  logic [2:0] model = 3'h0;
  logic [2:0] m;
  logic [11:0] p;
  logic [31:0] seed = 32'h0000C3EE;
  logic [31:0] r;
  int err_count = 0;
  int total_checks = 0;
  event chk;

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  pin_driver drv (.clk_in(ref_clk), .sa_n_out(sa), .sb_n_out(sb),
    .ca_n_out(ca), .cb_n_out(cb), .cc_n_out(cc), .ss_out(ss),
    .sc_out(sc), .ck_out(ck));

  uff_triple dut (.REF_CLK_IN(ref_clk), .RST_IN(rst),
    .DC_SET_A_N_IN(sa), .DC_SET_B_N_IN(sb), .DC_CLR_A_N_IN(ca),
    .DC_CLR_B_N_IN(cb), .COMMON_CLR_N_IN(cc), .STEER_SET_IN(ss),
    .STEER_CLR_IN(sc), .STAGE_CLK_IN(ck), .Q_OUT(q), .Q_N_OUT(qn));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Note the expected outputs once settled
  task automatic look(input logic [2:0] e, en);
    repeat (24) @(negedge ref_clk);
    notes.push_back({e, en});
    -> chk;
  endtask

  // Drive direct pins for n cycles, then release to idle
  task automatic dir(input logic [2:0] a, b, c, d, input logic e,
    input int n);
    drv.put(a, b, c, d, e, 3'h0, 3'h0, 3'h0, n);
    drv.put(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, 3'h0, 3'h0, 3'h0, 0);
  endtask

  always @(chk) begin
    logic [5:0] e;
    e = notes.pop_front();
    total_checks++;
    if ({q, qn} !== e) begin
      err_count++;
      $display("ERROR Q_OUT,Q_N_OUT expected %h seen %h", e, {q, qn});
    end
  end

  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    look(3'h0, 3'h7);
    for (int i = 0; i < 40; i++) begin
      r = xs();
      drv.put(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, r[2:0], r[5:3], r[8:6], 0);
      look(model, ~model);
      for (int s = 0; s < 3; s++)
        if (r[6+s])
          model[s] = (r[s] & r[3+s]) ? ~model[s] : r[s] | (~r[3+s] & model[s]);
      drv.put(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, r[2:0], r[5:3], 3'h0, 0);
      look(model, ~model);
    end
    dir(3'h0, 3'h7, 3'h7, 3'h7, 1'b1, 14);
    look(3'h7, 3'h0);
    dir(3'h7, 3'h7, 3'h7, 3'h7, 1'b0, 14);
    look(3'h0, 3'h7);
    model = 3'h0;
    for (int k = 0; k < 8; k++) begin
      m = 3'h1 << (k % 2);
      p = 12'hFFF ^ ({9'h0, m} << (3 * (k % 4)));
      dir(p[2:0], p[5:3], p[8:6], p[11:9], 1'b1, k < 4 ? 14 : 4);
      if (k < 4)
        model = (k < 2) ? model | m : model & ~m;
      look(model, ~model);
    end
    for (int i = 0; i < 4; i++) begin
      r = xs();
      dir(3'h7, 3'h7, 3'h7, 3'h7, 1'b0, 14);
      dir(~r[2:0], 3'h7, 3'h7, 3'h7, 1'b1, 14);
      model = r[2:0];
      look(model, ~model);
      r = xs();
      dir(3'h7, ~r[2:0], 3'h7, r[2:0], 1'b1, 14);
      model = r[2:0];
      look(model, ~model);
    end
    for (int t = 0; t < 6; t++) begin
      r = xs();
      m = {model[1:0], r[0]};
      model = m;
      drv.put(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, m, ~m, 3'h7, 6);
      drv.put(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, m, ~m, 3'h0, 0);
      look(model, ~model);
    end
    drv.put(3'h0, 3'h7, 3'h0, 3'h7, 1'b1, 3'h0, 3'h0, 3'h0, 0);
    look(3'h0, 3'h7);
    dir(3'h7, 3'h7, 3'h7, 3'h7, 1'b1, 0);
    look(3'h0, 3'h7);
    @(negedge ref_clk);
    if (notes.size() != 0) begin
      err_count++;
      $display("ERROR notes expected 0 seen %0d", notes.size());
    end
    tally_and_finish();
  end
endmodule
